// >>> ppx_pkg.sv
// How it works
// - Seventeen pins: two byte ports take crossbar signals, the lone pin is plain I/O.
// - Port level outputs always show the real pin levels, whatever the mapping.
// - Enabled functions are placed in fixed priority order, serial port first.
// - Serial transmit sits on pin 4, receive on pin 5, skip mask ignored.
// - Async comparator output only on pin 12, synced output only on pin 13.
// - A pin already given to a function is passed over by later functions.
// - Skipped pins count as assigned; the search moves to the next free pin.
// - Skip masks hold one bit per pin; 0x0c skips pins 2 and 3.
// - Serial port always takes both of its pins; management bus SCL gets no pin if only one free pin is left for SDA.
// - Pins left after placement act as general purpose I/O.
// - Slave select takes a pin only in 4-wire mode, never in 3-wire mode.
// - Input mode 1 means digital, 0 analog; all pins digital after reset.
// - Analog pins lose pull-up, output driver and input receiver.
// - Output mode bit picks open-drain or push-pull, also for peripheral pins other than SDA and SCL.
// - Management bus data and clock pins are always open-drain.
// - Pull-ups on open-drain pins unless disabled; off while driving low.
// - Matrix enable set to 1 puts the function selects into effect.
// - With the matrix off every driver is off; GPIO output needs it on.
package ppx_pkg;

  localparam int PPX_NPIN = 17;
  localparam int PPX_NXB = 16;

  typedef enum logic [4:0] {
    SIG_GPIO, SIG_TX, SIG_RX, SIG_SCK, SIG_MISO, SIG_MOSI, SIG_NSS,
    SIG_SDA, SIG_SCL, SIG_CP, SIG_CPA, SIG_SYSCLK,
    SIG_CEX0, SIG_CEX1, SIG_CEX2, SIG_ECI, SIG_T0, SIG_T1
  } ppx_sig_type;

  localparam int PPX_NSIG = 18;

  // Fixed pin positions
  localparam int PIN_TX = 4;
  localparam int PIN_RX = 5;
  localparam int PIN_CPA = 12;
  localparam int PIN_CP = 13;
  localparam logic [4:0] PIN_NONE = 5'h1f;

  // function_select_0 fields
  localparam int FS0_URT = 0;
  localparam int FS0_SPI = 1;
  localparam int FS0_SMB = 2;
  localparam int FS0_SYSCK = 3;
  localparam int FS0_CP = 4;
  localparam int FS0_CPA = 5;

  // function_select_1 fields
  localparam int FS1_PCA_LO = 0;
  localparam int FS1_ECI = 3;
  localparam int FS1_T0 = 4;
  localparam int FS1_T1 = 5;
  localparam int FS1_XBAR = 6;
  localparam int FS1_PUD = 7;

  // Values after reset
  localparam logic [16:0] IN_MODE_RST = 17'h1ffff;
  localparam logic [16:0] OUT_MODE_RST = 17'h00000;
  localparam logic [7:0] SKIP_RST = 8'h00;
  localparam logic [7:0] FSEL_RST = 8'h00;
  localparam logic [1:0] SSM_RST = 2'h0;
  localparam logic [1:0] SSM_3WIRE = 2'h0;

endpackage

// >>> ppx_map_if.sv
`timescale 1ns/1ps
interface ppx_map_if;
  import ppx_pkg::*;
  logic [PPX_NSIG-1:0] req;
  logic [PPX_NXB-1:0] skip;
  ppx_sig_type [PPX_NXB-1:0] sel;
  modport alloc (input req, input skip, output sel);
  modport user (output req, output skip, input sel);
endinterface

// >>> ppx_alloc.sv
`timescale 1ns/1ps
module ppx_alloc (
  ppx_map_if.alloc m
);
  import ppx_pkg::*;

  function automatic logic [4:0] ppx_lowest(input logic [PPX_NXB-1:0] taken);
    logic [4:0] idx;
    idx = PIN_NONE;
    for (int i = PPX_NXB - 1; i >= 0; i--) begin
      if (!taken[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  logic [PPX_NXB-1:0] taken;
  logic [4:0] idx;

  always_comb begin
    taken = m.skip;
    idx = PIN_NONE;
    for (int p = 0; p < PPX_NXB; p++) begin
      m.sel[p] = SIG_GPIO;
    end
    // Fixed pins win regardless of skip bits
    if (m.req[SIG_TX]) begin
      m.sel[PIN_TX] = SIG_TX;
      m.sel[PIN_RX] = SIG_RX;
      taken[PIN_TX] = 1'b1;
      taken[PIN_RX] = 1'b1;
    end
    if (m.req[SIG_CPA]) begin
      m.sel[PIN_CPA] = SIG_CPA;
      taken[PIN_CPA] = 1'b1;
    end
    if (m.req[SIG_CP]) begin
      m.sel[PIN_CP] = SIG_CP;
      taken[PIN_CP] = 1'b1;
    end
    // Priority walk; enum order is the priority order
    for (int k = SIG_SCK; k < PPX_NSIG; k++) begin
      if (m.req[k] && k != SIG_CP && k != SIG_CPA) begin
        idx = ppx_lowest(taken);
        if (idx != PIN_NONE) begin
          m.sel[idx[3:0]] = ppx_sig_type'(k);
          taken[idx[3:0]] = 1'b1;
        end
      end
    end
  end

endmodule

// >>> ppx_crossbar.sv
`timescale 1ns/1ps
module ppx_crossbar (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] port0_skip_mask,
  input wire logic [7:0] port1_skip_mask,
  input wire logic [ppx_pkg::PPX_NPIN-1:0] pin_input_mode,
  input wire logic [ppx_pkg::PPX_NPIN-1:0] pin_output_mode,
  input wire logic [7:0] function_select_0,
  input wire logic [7:0] function_select_1,
  input wire logic [1:0] slave_select_mode,
  input wire logic [ppx_pkg::PPX_NPIN-1:0] gpio_out,
  input wire logic [ppx_pkg::PPX_NSIG-1:0] periph_out,
  input wire logic [ppx_pkg::PPX_NSIG-1:0] periph_drive,
  input wire logic [ppx_pkg::PPX_NPIN-1:0] pin_in,
  output logic [ppx_pkg::PPX_NPIN-1:0] pin_out,
  output logic [ppx_pkg::PPX_NPIN-1:0] pin_oe,
  output logic [ppx_pkg::PPX_NPIN-1:0] pin_pullup_en,
  output logic [ppx_pkg::PPX_NPIN-1:0] pin_rx_en,
  output logic [ppx_pkg::PPX_NPIN-1:0] port_level,
  output logic [ppx_pkg::PPX_NSIG-1:0] periph_in,
  output logic [ppx_pkg::PPX_NXB-1:0] pin_assigned
);
  import ppx_pkg::*;

  // Configuration copies; reset values hold until software config arrives
  logic [PPX_NXB-1:0] skip_r;
  logic [PPX_NPIN-1:0] in_mode_r;
  logic [PPX_NPIN-1:0] out_mode_r;
  logic [7:0] fs0_r;
  logic [7:0] fs1_r;
  logic [1:0] ssm_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      skip_r <= {SKIP_RST, SKIP_RST};
      in_mode_r <= IN_MODE_RST;
      out_mode_r <= OUT_MODE_RST;
      fs0_r <= FSEL_RST;
      fs1_r <= FSEL_RST;
      ssm_r <= SSM_RST;
    end else begin
      skip_r <= {port1_skip_mask, port0_skip_mask};
      in_mode_r <= pin_input_mode;
      out_mode_r <= pin_output_mode;
      fs0_r <= function_select_0;
      fs1_r <= function_select_1;
      ssm_r <= slave_select_mode;
    end
  end

  logic xbar_en;
  logic pud;
  logic [1:0] pca_mode;

  assign xbar_en = fs1_r[FS1_XBAR];
  assign pud = fs1_r[FS1_PUD];
  assign pca_mode = fs1_r[FS1_PCA_LO +: 2];

  ppx_map_if map ();

  logic [PPX_NSIG-1:0] req;

  always_comb begin
    req = '0;
    req[SIG_TX] = fs0_r[FS0_URT];
    req[SIG_RX] = fs0_r[FS0_URT];
    req[SIG_SCK] = fs0_r[FS0_SPI];
    req[SIG_MISO] = fs0_r[FS0_SPI];
    req[SIG_MOSI] = fs0_r[FS0_SPI];
    req[SIG_NSS] = fs0_r[FS0_SPI] && (ssm_r != SSM_3WIRE);
    req[SIG_SDA] = fs0_r[FS0_SMB];
    req[SIG_SCL] = fs0_r[FS0_SMB];
    req[SIG_CP] = fs0_r[FS0_CP];
    req[SIG_CPA] = fs0_r[FS0_CPA];
    req[SIG_SYSCLK] = fs0_r[FS0_SYSCK];
    req[SIG_CEX0] = (pca_mode >= 2'h1);
    req[SIG_CEX1] = (pca_mode >= 2'h2);
    req[SIG_CEX2] = (pca_mode == 2'h3);
    req[SIG_ECI] = fs1_r[FS1_ECI];
    req[SIG_T0] = fs1_r[FS1_T0];
    req[SIG_T1] = fs1_r[FS1_T1];
  end

  assign map.req = req;
  assign map.skip = skip_r;

  ppx_alloc u_alloc (
    .m(map)
  );

  // Pin drive; the lone pin of the third port never carries a function
  ppx_sig_type sig;
  logic val;
  logic drv;
  logic od;
  logic en;
  logic [PPX_NPIN-1:0] out_nxt;
  logic [PPX_NPIN-1:0] oe_nxt;
  logic [PPX_NPIN-1:0] pu_nxt;
  logic [PPX_NPIN-1:0] rx_nxt;

  always_comb begin
    sig = SIG_GPIO;
    val = 1'b0;
    drv = 1'b0;
    od = 1'b0;
    en = 1'b0;
    out_nxt = '0;
    oe_nxt = '0;
    pu_nxt = '0;
    rx_nxt = '0;
    for (int p = 0; p < PPX_NPIN; p++) begin
      // With the matrix off every pin is plain port I/O, so no function forces open-drain
      sig = SIG_GPIO;
      if (p < PPX_NXB && xbar_en) begin
        sig = map.sel[4'(p)];
      end
      if (sig == SIG_GPIO) begin
        val = gpio_out[p];
        drv = 1'b1;
      end else begin
        val = periph_out[sig];
        drv = periph_drive[sig];
      end
      // Output mode 1 is push-pull, 0 open-drain
      od = !out_mode_r[p] || sig == SIG_SDA || sig == SIG_SCL;
      en = xbar_en && in_mode_r[p] && drv;
      // Open-drain only ever pulls low, so the high level comes from the pull-up
      oe_nxt[p] = en && (!od || !val);
      out_nxt[p] = od ? 1'b0 : val;
      // Pull-up dropped while driving low to save the sink current
      pu_nxt[p] = !pud && in_mode_r[p] && od && !(en && !val);
      rx_nxt[p] = in_mode_r[p];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pullup_en <= '0;
      pin_rx_en <= IN_MODE_RST;
    end else begin
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
      pin_pullup_en <= pu_nxt;
      pin_rx_en <= rx_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_level <= '0;
    end else begin
      port_level <= pin_in;
    end
  end

  // Inputs of unplaced or disabled functions idle high
  logic [PPX_NSIG-1:0] pin_nxt;
  logic [PPX_NXB-1:0] asg_nxt;

  always_comb begin
    pin_nxt = '1;
    asg_nxt = '0;
    for (int p = 0; p < PPX_NXB; p++) begin
      if (map.sel[p] != SIG_GPIO) begin
        asg_nxt[p] = xbar_en;
        if (xbar_en && in_mode_r[p]) begin
          pin_nxt[map.sel[p]] = pin_in[p];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      periph_in <= '1;
      pin_assigned <= '0;
    end else begin
      periph_in <= pin_nxt;
      pin_assigned <= asg_nxt;
    end
  end

endmodule

// >>> ppx_board.sv
`timescale 1ns/1ps
module ppx_board (
  input logic clk,
  input logic [16:0] drv,
  input logic [16:0] oe,
  input logic [16:0] pu,
  input logic [16:0] ext_en,
  input logic [16:0] ext_val,
  output logic [16:0] lvl
);
  logic [16:0] flt_r = 17'h0aaaa;
  // A floating pin toggles so a stale level never passes for a real one
  always_ff @(posedge clk) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 17; i++) begin
      lvl[i] = oe[i] ? drv[i] : ext_en[i] ? ext_val[i] : pu[i] | flt_r[i];
    end
  end
endmodule

// >>> ppx_crossbar_chk.sv
`timescale 1ns/1ps
module ppx_crossbar_chk
  import ppx_pkg::*;
(
  input logic clk,
  input logic rst,
  input logic [7:0] function_select_0,
  input logic [7:0] function_select_1,
  input logic [16:0] pin_input_mode,
  input logic [16:0] pin_output_mode,
  input logic [16:0] pin_in,
  input logic [17:0] periph_out,
  input logic [17:0] periph_drive,
  input logic [16:0] pin_out,
  input logic [16:0] pin_oe,
  input logic [16:0] pin_pullup_en,
  input logic [16:0] pin_rx_en,
  input logic [16:0] port_level,
  input logic [17:0] periph_in,
  input logic [15:0] pin_assigned
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] up_r;
  // Outputs trail config by two edges, so config checks wait two clean edges; the port level check waits one
  always_ff @(posedge clk) up_r <= rst ? 2'h0 : {up_r[0], 1'b1};
  wire en = function_select_1[FS1_XBAR];
  wire urt = en & function_select_0[FS0_URT];
  wire smb = en & function_select_0[FS0_SMB];
  wire tx_pp = urt & pin_output_mode[PIN_TX] & pin_input_mode[PIN_TX];
  wire rx_dg = urt & pin_input_mode[PIN_RX];
  wire cp_pp = en & function_select_0[FS0_CP] & pin_output_mode[PIN_CP] &
    pin_input_mode[PIN_CP];
  wire cpa_pp = en & function_select_0[FS0_CPA] & pin_output_mode[PIN_CPA] &
    pin_input_mode[PIN_CPA];
  property p_lvl; up_r[0] |-> port_level == $past(pin_in); endproperty
  a_lvl: assert property (p_lvl) else $error("port level");
  property p_off; up_r[1] && !$past(en, 2) |-> pin_oe == 17'h0 && pin_assigned == 16'h0;
  endproperty
  a_off: assert property (p_off) else $error("driver while off");
  // Pins 12 and 13 may also go to walked functions, so only the selected ones are demanded
  property p_cmp; up_r[1] && $past(en, 2) |-> (~pin_assigned[13:12] &
    {$past(function_select_0[FS0_CP], 2), $past(function_select_0[FS0_CPA], 2)}) == 2'h0;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator pins");
  property p_cpo; up_r[1] && $past(cp_pp, 2) && $past(periph_drive[SIG_CP]) |->
    pin_oe[PIN_CP] && pin_out[PIN_CP] == $past(periph_out[SIG_CP]); endproperty
  a_cpo: assert property (p_cpo) else $error("sync comparator pin");
  property p_cpa; up_r[1] && $past(cpa_pp, 2) && $past(periph_drive[SIG_CPA]) |->
    pin_oe[PIN_CPA] && pin_out[PIN_CPA] == $past(periph_out[SIG_CPA]); endproperty
  a_cpa: assert property (p_cpa) else $error("async comparator pin");
  property p_urt; up_r[1] && $past(urt, 2) |-> pin_assigned[5:4] == 2'h3; endproperty
  a_urt: assert property (p_urt) else $error("serial pair");
  property p_tx; up_r[1] && $past(tx_pp, 2) && $past(periph_drive[SIG_TX]) |->
    pin_oe[PIN_TX] && pin_out[PIN_TX] == $past(periph_out[SIG_TX]); endproperty
  a_tx: assert property (p_tx) else $error("transmit pin");
  property p_rx; up_r[1] && $past(rx_dg, 2) |-> periph_in[SIG_RX] == $past(pin_in[PIN_RX]);
  endproperty
  a_rx: assert property (p_rx) else $error("receive pin");
  property p_ana; up_r[1] |->
    ((pin_oe | pin_pullup_en | pin_rx_en) & ~$past(pin_input_mode, 2)) == 17'h0; endproperty
  a_ana: assert property (p_ana) else $error("analog pin active");
  property p_od; up_r[1] |-> (pin_out & pin_oe & ~$past(pin_output_mode, 2)) == 17'h0;
  endproperty
  a_od: assert property (p_od) else $error("open drain high");
  property p_pu; up_r[1] && !$past(smb, 2) |-> pin_pullup_en ==
    ($past(function_select_1[FS1_PUD], 2) ? 17'h0 : ~$past(pin_output_mode, 2) &
    $past(pin_input_mode, 2) & ~(pin_oe & ~pin_out)); endproperty
  a_pu: assert property (p_pu) else $error("pull-up");
endmodule
bind ppx_crossbar ppx_crossbar_chk u_chk (.clk, .rst, .function_select_0, .function_select_1,
  .pin_input_mode, .pin_output_mode, .pin_in, .periph_out, .periph_drive, .pin_out, .pin_oe,
  .pin_pullup_en, .pin_rx_en, .port_level, .periph_in, .pin_assigned);

// >>> priority_port_crossbar_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module priority_port_crossbar_test;
  import ppx_pkg::*;
  logic clk = 0, rst = 1;
  logic [7:0] s0 = 0, s1 = 0, f0 = 0, f1 = 0;
  logic [1:0] ssm = 0;
  logic [16:0] im = '1, om = 0, go = 0, xe = 0, xv = 0, lv, pi, po, oe, pu, rx, pl;
  logic [17:0] dout = 0, ddrv = 0, din;
  logic [15:0] asg;
  logic [31:0] rs = 32'ha060bc0a, ds = 32'ha060bc0a, r1;
  int n_fail = 0, n_compared = 0, cyc = 0;
  always #12.5 clk = ~clk;
  ppx_board u_board (.clk(clk), .drv(po), .oe(oe), .pu(pu), .ext_en(xe), .ext_val(xv), .lvl(pi));
  ppx_crossbar DUT (.clk(clk), .rst(rst), .port0_skip_mask(s0), .port1_skip_mask(s1),
    .pin_input_mode(im), .pin_output_mode(om), .function_select_0(f0),
    .function_select_1(f1), .slave_select_mode(ssm), .gpio_out(go), .periph_out(dout),
    .periph_drive(ddrv), .pin_in(pi), .pin_out(po), .pin_oe(oe), .pin_pullup_en(pu),
    .pin_rx_en(rx), .port_level(pl), .periph_in(din), .pin_assigned(asg));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_asg(input logic [7:0] a, b, input logic [1:0] m,
                                          input logic [15:0] sk);
    logic [15:0] r;
    int n;
    if (!b[6]) return 16'h0;
    r = {2'h0, a[4], a[5], 6'h0, {2{a[0]}}, 4'h0};
    n = (a[1] ? (m != 0 ? 4 : 3) : 0) + (a[2] ? 2 : 0) + a[3] + b[1:0] + b[3] + b[4] + b[5];
    sk = sk | r;
    for (int p = 0; p < 16; p++) begin
      if (!sk[p] && n > 0) begin
        r[p] = 1'b1;
        n--;
      end
    end
    return r;
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Data lines move every cycle; only output signals are ever driven
  always @(posedge clk) begin
    #2;
    ds = lfsr(ds);
    dout = ds[17:0];
    ddrv = ds[31:14] & 18'h07fea;
    go = ds[16:0];
    xe = ~ds[30:14];
    xv = ds[26:10];
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic run(input logic [7:0] a, b, input logic [1:0] m, input logic [15:0] sk,
                     input logic [16:0] o, i);
    f1[FS1_XBAR] = 1'b0;
    step(1);
    im = i;
    step(1);
    om = o;
    step(1);
    {s1, s0} = sk;
    step(1);
    f0 = a;
    ssm = m;
    f1 = b & 8'hbf;
    step(1);
    f1 = b;
    step(3);
    `CHK("assigned", exp_asg(a, b, m, sk), asg)
    if (!b[FS1_XBAR]) `CHK("drivers", 17'h0, oe)
    @(negedge clk) lv = pi;
    step(1);
    `CHK("port level", lv, pl)
    $display("test done select %h %h skip %h", a, b, sk);
  endtask
  initial begin
    step(16);
    rst = 0;
    step(1);
    `CHK("receivers", 17'h1ffff, rx)
    `CHK("drivers", 17'h0, oe)
    run(8'h07, 8'h40, 2'h1, 16'h000c, '1, '1);
    `CHK("mgmt pins", 2'h0, po[9:8])
    run(8'h02, 8'h40, 2'h0, 16'h0, '0, '1);
    run(8'h3f, 8'h7b, 2'h1, 16'hffff, '0, '1);
    run(8'h3f, 8'h7b, 2'h1, 16'h0, '0, '1);
    run(8'h3f, 8'h3b, 2'h1, 16'h0, '1, '1);
    repeat (40) begin
      repeat (32) rs = lfsr(rs);
      r1 = rs;
      repeat (32) rs = lfsr(rs);
      run(r1[7:0] & 8'h3f, r1[15:8] & 8'hfb, r1[17:16], rs[15:0] & rs[31:16], rs[16:0],
          r1[31:15] | rs[31:15]);
    end
    report_and_stop();
  end
endmodule
